// >>> shared/amp_cfg_pkg.sv
// Package with offsets, reset values, field positions and hold-time figures of the config bank.
package amp_cfg_pkg;

	// ****************************************
	// Register offsets on the control port
	// ****************************************
	localparam logic [7:0] AUTOMUTE_ENABLE_CTRL_OFS = 8'h50;
	localparam logic [7:0] ZERO_RUN_HOLD_TIME_OFS = 8'h51;
	localparam logic [7:0] LOOP_BANDWIDTH_SELECT_OFS = 8'h53;
	localparam logic [7:0] OUTPUT_ATTENUATION_OFS = 8'h54;
	localparam logic [7:0] FILTER_COEF_WRITE_MARKER_OFS = 8'h5c;
	localparam logic [7:0] MODULATOR_SETTINGS_OFS = 8'h5d;

	// ****************************************
	// Reset values
	// ****************************************
	localparam logic [7:0] AUTOMUTE_ENABLE_CTRL_RST = 8'h07;
	localparam logic [7:0] ZERO_RUN_HOLD_TIME_RST = 8'h00;
	localparam logic [7:0] LOOP_BANDWIDTH_SELECT_RST = 8'h00;
	localparam logic [7:0] OUTPUT_ATTENUATION_RST = 8'h00;
	localparam logic [7:0] FILTER_COEF_WRITE_MARKER_RST = 8'h00;
	localparam logic [7:0] MODULATOR_SETTINGS_RST = 8'hf8;
	localparam logic [7:0] READ_UNMAPPED_VAL = 8'h00;

	// ****************************************
	// Field positions
	// ****************************************
	localparam int LEFT_MUTE_EN_BIT = 0;
	localparam int RIGHT_MUTE_EN_BIT = 1;
	localparam int JOINT_MUTE_BIT = 2;
	localparam int HOLD_SEL_W = 3;
	localparam int LEFT_HOLD_LSB = 4;
	localparam int RIGHT_HOLD_LSB = 0;
	localparam int LOOP_BW_LSB = 5;
	localparam int LOOP_BW_W = 2;
	localparam int ATTEN_LSB = 0;
	localparam int ATTEN_W = 5;
	localparam int FIRST_COEF_BIT = 0;
	localparam int DAC_RATE_BIT = 7;
	localparam int DITHER_MAIN_BIT = 5;
	localparam int DITHER_SECOND_BIT = 6;
	localparam int DITHER_LEVEL_LSB = 2;
	localparam int DITHER_LEVEL_W = 3;
	localparam int ELEMENT_MATCHING_LSB = 0;
	localparam int ELEMENT_MATCHING_W = 2;
	localparam logic [1:0] ELEMENT_MATCHING_ON = 2'h0;

	// ****************************************
	// Dither level exponents
	// ****************************************
	localparam logic [4:0] DITHER_EXP_HIGH_BASE = 5'h07;
	localparam logic [4:0] DITHER_EXP_LOW_BASE = 5'h0d;

	// ****************************************
	// Zero-run hold times, in microseconds at the reference sample rate
	// ****************************************
	localparam int unsigned HOLD_RATE_KHZ = 96;
	localparam int unsigned US_PER_MS = 1000;
	localparam int unsigned HOLD_TIME_US [8] = '{11500, 53000, 106500, 266500,
		535000, 1065000, 2665000, 5330000};
	localparam int HOLD_CNT_W = 19;
	localparam int NUM_CH = 2;

endpackage : amp_cfg_pkg

// >>> shared/zero_run_if.sv
// Interface carrying one channel's sample-valid and zero flags and hold length to its zero-run detector, and its qualified flag back.
`timescale 1ns/1ps
interface zero_run_if import amp_cfg_pkg::*; ();
	logic sample_valid;
	logic sample_zero;
	logic [HOLD_CNT_W-1:0] hold_count;
	logic qualified;

	modport ctrl (
		output sample_valid,
		output sample_zero,
		output hold_count,
		input qualified
	);

	modport det (
		input sample_valid,
		input sample_zero,
		input hold_count,
		output qualified
	);
endinterface : zero_run_if

// >>> tb/amp_automute_dac_config_regs_tb.sv
// Directed bench for the config bank and its auto-mute.
`timescale 1ns/1ps
module amp_automute_dac_config_regs_tb
	import amp_cfg_pkg::*;
;
	// A large divider keeps the longest hold at a few hundred samples.
	localparam int unsigned DIV = 1024;
	logic ref_clk = 1'b0, reset_n = 1'b0, ce = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
	logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
	logic sample_valid = 1'b0, reg_rvalid, left_mute, right_mute, first_filter_coef_flag;
	logic [23:0] left_sample = 24'h000000, right_sample = 24'h000000;
	logic [1:0] loop_bw_sel;
	logic [4:0] output_atten_code, dither_exponent;
	logic [2:0] dither_level_code, k;
	logic dac_rate_sel, dither_main_en, dither_second_en, element_matching_en;
	logic [7:0] v, ofs [6] = '{8'h50, 8'h51, 8'h53, 8'h54, 8'h5c, 8'h5d};
	logic [7:0] rst [6] = '{8'h07, 8'h00, 8'h00, 8'h00, 8'h00, 8'hf8};
	int error_cnt = 0, compares = 0, cycles = 0;
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin error_cnt++; $display("BAD %s exp %0h got %0h", n, e, g); end end
	amp_automute_dac_config_regs #(.SAMPLE_W(24), .HOLD_DIV(DIV)) amp_automute_dac_config_regs_inst (
		.ref_clk(ref_clk), .reset_n(reset_n), .ce(ce), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.reg_rvalid(reg_rvalid), .sample_valid(sample_valid), .left_sample(left_sample),
		.right_sample(right_sample), .left_mute(left_mute), .right_mute(right_mute),
		.loop_bw_sel(loop_bw_sel), .output_atten_code(output_atten_code),
		.first_filter_coef_flag(first_filter_coef_flag), .dac_rate_sel(dac_rate_sel),
		.dither_main_en(dither_main_en), .dither_second_en(dither_second_en),
		.dither_level_code(dither_level_code), .dither_exponent(dither_exponent),
		.element_matching_en(element_matching_en));
	initial begin
		forever #2 ref_clk = ~ref_clk;
	end
	task test_done;
		if (error_cnt == 0 && compares > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : test_done
	task wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
		#1;
	endtask : wr
	task rd(input logic [7:0] a, input logic [7:0] e);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge ref_clk);
		reg_rd <= 1'b0;
		#1;
		`CHK("rvalid", 1'b1, reg_rvalid)
		`CHK("rdata", e, reg_rdata)
	endtask : rd
	// Arguments flag a non-zero sample on the left and right channel.
	task smp(input logic l, input logic r);
		@(posedge ref_clk);
		sample_valid <= 1'b1;
		left_sample <= 24'(l);
		right_sample <= 24'(r);
		@(posedge ref_clk);
		sample_valid <= 1'b0;
		@(posedge ref_clk);
		#1;
	endtask : smp
	task hold(input logic ch, input logic [2:0] c);
		int unsigned n;
		n = HOLD_TIME_US[c] * HOLD_RATE_KHZ / US_PER_MS / DIV;
		if (n < 1)
			n = 1;
		wr(8'h51, ch ? {5'h00, c} : {1'b0, c, 4'h0});
		smp(1'b1, 1'b1);
		repeat (n - 1) smp(ch, !ch);
		`CHK("early", 1'b0, ch ? right_mute : left_mute)
		smp(ch, !ch);
		`CHK("mute", 1'b1, ch ? right_mute : left_mute)
		`CHK("other", 1'b0, ch ? left_mute : right_mute)
		smp(1'b1, 1'b1);
		`CHK("release", 1'b0, ch ? right_mute : left_mute)
	endtask : hold
	initial begin
		repeat (3) @(posedge ref_clk);
		reset_n <= 1'b1;
		ce <= 1'b1;
		for (int i = 0; i < 6; i++) rd(ofs[i], rst[i]);
		`CHK("exponent", 5'h09, dither_exponent)
		`CHK("matching", 1'b1, element_matching_en)
		for (int i = 0; i < 6; i++) begin
			wr(ofs[i], 8'hff);
			rd(ofs[i], 8'hff);
			wr(ofs[i], rst[i]);
		end
		wr(8'h52, 8'h5a);
		rd(8'h52, 8'h00);
		wr(8'h54, 8'h1f);
		`CHK("atten", 5'h1f, output_atten_code)
		for (int i = 0; i < 4; i++) begin
			wr(8'h53, 8'(i << 5));
			`CHK("bandwidth", 2'(i), loop_bw_sel)
		end
		for (int i = 0; i < 8; i++) begin
			k = 3'(i);
			v = {k[0], k[1:0], k, k[1:0]};
			wr(8'h5d, v);
			`CHK("rate", v[7], dac_rate_sel)
			`CHK("dither", v[6:5], {dither_second_en, dither_main_en})
			`CHK("level", k, dither_level_code)
			`CHK("exp", (k[2] ? 5'h07 : 5'h0d) + {3'h0, k[1:0]}, dither_exponent)
			`CHK("match", (k[1:0] == 2'h0), element_matching_en)
		end
		wr(8'h5c, 8'h01);
		`CHK("marker", 1'b1, first_filter_coef_flag)
		wr(8'h50, 8'h03);
		for (int i = 0; i < 8; i++) begin
			hold(1'b0, 3'(i));
			hold(1'b1, 3'(i));
		end
		wr(8'h50, 8'h02);
		wr(8'h51, 8'h00);
		smp(1'b0, 1'b1);
		smp(1'b0, 1'b1);
		`CHK("disabled", 1'b0, left_mute)
		wr(8'h50, 8'h07);
		smp(1'b0, 1'b1);
		`CHK("joint wait", 2'b00, {left_mute, right_mute})
		smp(1'b0, 1'b0);
		`CHK("joint mute", 2'b11, {left_mute, right_mute})
		smp(1'b1, 1'b0);
		`CHK("joint free", 2'b00, {left_mute, right_mute})
		test_done();
	end
	always @(posedge ref_clk) begin
		cycles++;
		if (cycles > 20000) begin
			error_cnt++;
			test_done();
		end
	end
endmodule : amp_automute_dac_config_regs_tb

// >>> tb/amp_cfg_regs_assertions.sv
// Concurrent checks on the ports of the config bank.
`timescale 1ns/1ps
module amp_cfg_regs_assertions
	import amp_cfg_pkg::*;
#(
	parameter int SAMPLE_W = 24,
	parameter int unsigned HOLD_DIV = 1
) (
	input wire logic ref_clk,
	input wire logic reset_n,
	input wire logic ce,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_rdata,
	input wire logic reg_rvalid,
	input wire logic sample_valid,
	input wire logic [SAMPLE_W-1:0] left_sample,
	input wire logic [SAMPLE_W-1:0] right_sample,
	input wire logic left_mute,
	input wire logic right_mute,
	input wire logic [LOOP_BW_W-1:0] loop_bw_sel,
	input wire logic [ATTEN_W-1:0] output_atten_code,
	input wire logic first_filter_coef_flag,
	input wire logic dac_rate_sel,
	input wire logic dither_main_en,
	input wire logic dither_second_en,
	input wire logic [DITHER_LEVEL_W-1:0] dither_level_code,
	input wire logic [4:0] dither_exponent,
	input wire logic element_matching_en
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!reset_n);
	logic wr_ok;
	logic rd_ok;
	assign wr_ok = ce && reg_wr;
	assign rd_ok = ce && reg_rd;
	// The second step needs ce, since a frozen block may not release its mute.
	sequence left_release_s;
		ce && sample_valid && (left_sample != '0) ##1 ce;
	endsequence
	chk_read_answered: assert property (
		rd_ok |=> reg_rvalid)
		else $error("read not answered");
	// A frozen block keeps its answer pulse, so only a running cycle without read clears it.
	chk_valid_pulse: assert property (
		ce && !reg_rd |=> !reg_rvalid)
		else $error("answer without read");
	chk_unmapped_zero: assert property (
		rd_ok && !(reg_addr inside {8'h50, 8'h51, 8'h53, 8'h54, 8'h5c, 8'h5d})
		|=> reg_rdata == 8'h00)
		else $error("unmapped read not zero");
	chk_atten_write: assert property (
		wr_ok && reg_addr == 8'h54 |=> output_atten_code == $past(reg_wdata[4:0]))
		else $error("attenuation not updated");
	chk_bw_write: assert property (
		wr_ok && reg_addr == 8'h53 |=> loop_bw_sel == $past(reg_wdata[6:5]))
		else $error("bandwidth not updated");
	chk_marker_write: assert property (
		wr_ok && reg_addr == 8'h5c |=> first_filter_coef_flag == $past(reg_wdata[0]))
		else $error("marker not updated");
	chk_rate_write: assert property (
		wr_ok && reg_addr == 8'h5d |=> dac_rate_sel == $past(reg_wdata[7]))
		else $error("rate not updated");
	chk_dither_write: assert property (
		wr_ok && reg_addr == 8'h5d |=>
		{dither_second_en, dither_main_en, dither_level_code} == $past(reg_wdata[6:2]))
		else $error("dither fields not updated");
	chk_match_write: assert property (
		wr_ok && reg_addr == 8'h5d |=>
		element_matching_en == ($past(reg_wdata[1:0]) == 2'h0))
		else $error("matching enable wrong");
	chk_exp_map: assert property (
		dither_exponent == (dither_level_code[2] ? 5'h07 : 5'h0d) + {3'h0, dither_level_code[1:0]})
		else $error("dither exponent wrong");
	chk_left_release: assert property (
		left_release_s |=> !left_mute)
		else $error("left mute not released");
endmodule : amp_cfg_regs_assertions

bind amp_automute_dac_config_regs amp_cfg_regs_assertions #(.SAMPLE_W(SAMPLE_W), .HOLD_DIV(HOLD_DIV))
	chk_inst (.ref_clk(ref_clk), .reset_n(reset_n), .ce(ce), .reg_addr(reg_addr),
	.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
	.reg_rvalid(reg_rvalid), .sample_valid(sample_valid), .left_sample(left_sample),
	.right_sample(right_sample), .left_mute(left_mute), .right_mute(right_mute),
	.loop_bw_sel(loop_bw_sel), .output_atten_code(output_atten_code),
	.first_filter_coef_flag(first_filter_coef_flag), .dac_rate_sel(dac_rate_sel),
	.dither_main_en(dither_main_en), .dither_second_en(dither_second_en),
	.dither_level_code(dither_level_code), .dither_exponent(dither_exponent),
	.element_matching_en(element_matching_en));

// >>> verilog/amp_automute_dac_config_regs.sv
// Configuration register bank with per-channel auto-mute of the class-D amplifier.
`timescale 1ns/1ps
module amp_automute_dac_config_regs
	import amp_cfg_pkg::*;
#(
	parameter int SAMPLE_W = 24,
	parameter int unsigned HOLD_DIV = 1
) (
	input wire logic ref_clk,
	input wire logic reset_n,
	input wire logic ce,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	output logic reg_rvalid,
	input wire logic sample_valid,
	input wire logic [SAMPLE_W-1:0] left_sample,
	input wire logic [SAMPLE_W-1:0] right_sample,
	output logic left_mute,
	output logic right_mute,
	output logic [LOOP_BW_W-1:0] loop_bw_sel,
	output logic [ATTEN_W-1:0] output_atten_code,
	output logic first_filter_coef_flag,
	output logic dac_rate_sel,
	output logic dither_main_en,
	output logic dither_second_en,
	output logic [DITHER_LEVEL_W-1:0] dither_level_code,
	output logic [4:0] dither_exponent,
	output logic element_matching_en
);

	// ****************************************
	// State
	// ****************************************
	typedef struct packed {
		logic [7:0] automute_enable_ctrl;
		logic [7:0] zero_run_hold_time;
		logic [7:0] loop_bandwidth_select;
		logic [7:0] output_attenuation;
		logic [7:0] filter_coef_write_marker;
		logic [7:0] modulator_settings;
		logic [7:0] rdata;
		logic rvalid;
		logic left_mute;
		logic right_mute;
		logic [4:0] dither_exp;
		logic element_matching_en;
	} cfg_state_s;

	localparam cfg_state_s STATE_RST = '{
		automute_enable_ctrl: AUTOMUTE_ENABLE_CTRL_RST,
		zero_run_hold_time: ZERO_RUN_HOLD_TIME_RST,
		loop_bandwidth_select: LOOP_BANDWIDTH_SELECT_RST,
		output_attenuation: OUTPUT_ATTENUATION_RST,
		filter_coef_write_marker: FILTER_COEF_WRITE_MARKER_RST,
		modulator_settings: MODULATOR_SETTINGS_RST,
		rdata: READ_UNMAPPED_VAL,
		rvalid: 1'b0,
		left_mute: 1'b0,
		right_mute: 1'b0,
		dither_exp: DITHER_EXP_HIGH_BASE + 5'h02,
		element_matching_en: 1'b1
	};

	localparam int HOLD_SEL_LSB [NUM_CH] = '{LEFT_HOLD_LSB, RIGHT_HOLD_LSB};

	cfg_state_s state_reg;
	cfg_state_s state_next;
	logic [NUM_CH-1:0] ch_qual;
	logic [SAMPLE_W-1:0] ch_sample [NUM_CH];

	// ****************************************
	// Helpers
	// ****************************************
	// Hold lengths are sample counts, so the real time follows the sample rate.
	function automatic logic [HOLD_CNT_W-1:0] hold_samples(input logic [HOLD_SEL_W-1:0] sel);
		int unsigned n;
		n = HOLD_TIME_US[sel] * HOLD_RATE_KHZ / US_PER_MS;
		n = n / HOLD_DIV;
		if (n == 0) begin
			n = 1;
		end
		return n[HOLD_CNT_W-1:0];
	endfunction : hold_samples

	// Codes 1xx give the large amplitudes, 0xx the small ones.
	function automatic logic [4:0] dither_exp_of(input logic [DITHER_LEVEL_W-1:0] code);
		logic [4:0] base;
		base = code[2] ? DITHER_EXP_HIGH_BASE : DITHER_EXP_LOW_BASE;
		return base + {3'h0, code[1:0]};
	endfunction : dither_exp_of

	// ****************************************
	// Per-channel zero-run detectors
	// ****************************************
	assign ch_sample[0] = left_sample;
	assign ch_sample[1] = right_sample;

	generate
		for (genvar ch = 0; ch < NUM_CH; ch++) begin : g_ch
			zero_run_if zr_if ();

			assign zr_if.sample_valid = sample_valid;
			assign zr_if.sample_zero = (ch_sample[ch] == '0);
			// Right code 011 is not listed; it is given the same length as the left one.
			assign zr_if.hold_count = hold_samples(
				state_reg.zero_run_hold_time[HOLD_SEL_LSB[ch] +: HOLD_SEL_W]);
			assign ch_qual[ch] = zr_if.qualified;

			zero_run_detector u_det (
				.ref_clk(ref_clk),
				.reset_n(reset_n),
				.ce(ce),
				.zr(zr_if.det)
			);
		end
	endgenerate

	// ****************************************
	// Next-state logic
	// ****************************************
	always_comb begin
		logic q_left;
		logic q_right;
		logic [7:0] mod_next;
		q_left = 1'b0;
		q_right = 1'b0;
		mod_next = 8'h00;
		state_next = state_reg;

		// Full bytes are stored, so reserved bits read back what was written.
		if (reg_wr) begin
			case (reg_addr)
				AUTOMUTE_ENABLE_CTRL_OFS: begin
					state_next.automute_enable_ctrl = reg_wdata;
				end
				ZERO_RUN_HOLD_TIME_OFS: begin
					state_next.zero_run_hold_time = reg_wdata;
				end
				LOOP_BANDWIDTH_SELECT_OFS: begin
					state_next.loop_bandwidth_select = reg_wdata;
				end
				OUTPUT_ATTENUATION_OFS: begin
					state_next.output_attenuation = reg_wdata;
				end
				FILTER_COEF_WRITE_MARKER_OFS: begin
					state_next.filter_coef_write_marker = reg_wdata;
				end
				MODULATOR_SETTINGS_OFS: begin
					state_next.modulator_settings = reg_wdata;
				end
				default: begin
					state_next.rvalid = state_next.rvalid;
				end
			endcase
		end

		// Read data reflects the stored value before a write in the same cycle.
		state_next.rvalid = reg_rd;
		if (reg_rd) begin
			case (reg_addr)
				AUTOMUTE_ENABLE_CTRL_OFS: begin
					state_next.rdata = state_reg.automute_enable_ctrl;
				end
				ZERO_RUN_HOLD_TIME_OFS: begin
					state_next.rdata = state_reg.zero_run_hold_time;
				end
				LOOP_BANDWIDTH_SELECT_OFS: begin
					state_next.rdata = state_reg.loop_bandwidth_select;
				end
				OUTPUT_ATTENUATION_OFS: begin
					state_next.rdata = state_reg.output_attenuation;
				end
				FILTER_COEF_WRITE_MARKER_OFS: begin
					state_next.rdata = state_reg.filter_coef_write_marker;
				end
				MODULATOR_SETTINGS_OFS: begin
					state_next.rdata = state_reg.modulator_settings;
				end
				default: begin
					state_next.rdata = READ_UNMAPPED_VAL;
				end
			endcase
		end

		// Auto-mute decision, taken from the enables in force this cycle.
		q_left = ch_qual[0] & state_reg.automute_enable_ctrl[LEFT_MUTE_EN_BIT];
		q_right = ch_qual[1] & state_reg.automute_enable_ctrl[RIGHT_MUTE_EN_BIT];
		if (state_reg.automute_enable_ctrl[JOINT_MUTE_BIT]) begin
			state_next.left_mute = q_left & q_right;
			state_next.right_mute = q_left & q_right;
		end else begin
			state_next.left_mute = q_left;
			state_next.right_mute = q_right;
		end

		// Decoded modulator settings follow the byte that will be stored.
		mod_next = state_next.modulator_settings;
		state_next.dither_exp = dither_exp_of(mod_next[DITHER_LEVEL_LSB +: DITHER_LEVEL_W]);
		// Codes 01 and 10 are undefined; only 00 turns matching on, which is the safe side.
		state_next.element_matching_en =
			(mod_next[ELEMENT_MATCHING_LSB +: ELEMENT_MATCHING_W] == ELEMENT_MATCHING_ON);
	end

	// ****************************************
	// State register
	// ****************************************
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			state_reg <= STATE_RST;
		end else if (ce) begin
			state_reg <= state_next;
		end
	end

	// ****************************************
	// Outputs
	// ****************************************
	assign reg_rdata = state_reg.rdata;
	assign reg_rvalid = state_reg.rvalid;
	assign left_mute = state_reg.left_mute;
	assign right_mute = state_reg.right_mute;
	assign loop_bw_sel = state_reg.loop_bandwidth_select[LOOP_BW_LSB +: LOOP_BW_W];
	assign output_atten_code = state_reg.output_attenuation[ATTEN_LSB +: ATTEN_W];
	assign first_filter_coef_flag = state_reg.filter_coef_write_marker[FIRST_COEF_BIT];
	assign dac_rate_sel = state_reg.modulator_settings[DAC_RATE_BIT];
	assign dither_main_en = state_reg.modulator_settings[DITHER_MAIN_BIT];
	assign dither_second_en = state_reg.modulator_settings[DITHER_SECOND_BIT];
	assign dither_level_code = state_reg.modulator_settings[DITHER_LEVEL_LSB +: DITHER_LEVEL_W];
	assign dither_exponent = state_reg.dither_exp;
	assign element_matching_en = state_reg.element_matching_en;

endmodule : amp_automute_dac_config_regs

// >>> verilog/zero_run_detector.sv
// Consecutive-zero sample counter for one audio channel.
`timescale 1ns/1ps
module zero_run_detector
	import amp_cfg_pkg::*;
(
	input wire logic ref_clk,
	input wire logic reset_n,
	input wire logic ce,
	zero_run_if.det zr
);

	typedef struct packed {
		logic [HOLD_CNT_W-1:0] cnt;
	} det_state_s;

	det_state_s state_reg;
	det_state_s state_next;

	// ****************************************
	// Counter
	// ****************************************
	// The counter saturates at the hold length, so it never wraps back to an unmuted state.
	always_comb begin
		state_next = state_reg;
		if (zr.sample_valid) begin
			if (!zr.sample_zero) begin
				state_next.cnt = '0;
			end else if (state_reg.cnt < zr.hold_count) begin
				state_next.cnt = state_reg.cnt + 1'b1;
			end
		end
	end

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			state_reg <= '0;
		end else if (ce) begin
			state_reg <= state_next;
		end
	end

	// A shortened hold length takes effect at once on a run already counted.
	assign zr.qualified = (state_reg.cnt >= zr.hold_count);

endmodule : zero_run_detector
